// ==== design/vic_pkg.sv ====
/*
  Constants for the interrupt controller control and status block: register map,
  field positions, masks and reset values.
  Assumes a 32-bit AXI4-Lite register bus and one system clock.
*/
package vic_pkg;
  localparam int ADDR_W   = 12;
  localparam int DATA_W   = 32;
  localparam int NUM_SRC  = 32;
  localparam int NUM_EXT  = 5;
  localparam int NUM_PRIW = 8;
  localparam int SLOT_W   = 8;
  localparam int PRI_LSB  = 2;
  localparam int SUB_LSB  = 0;
  localparam int IDX_W    = 6;

  // Register index is addr[11:4]; addr[3:2] picks the plain, clear, set or invert alias
  localparam int IDX_LSB = 4;
  localparam int OP_LSB  = 2;
  localparam logic [7:0] IDX_CTRL  = 8'h00;
  localparam logic [7:0] IDX_STATE = 8'h01;
  localparam logic [7:0] IDX_PROX  = 8'h02;
  localparam logic [7:0] IDX_FLAG  = 8'h03;
  localparam logic [7:0] IDX_EN    = 8'h04;
  localparam logic [7:0] IDX_PRIO0 = 8'h05;
  localparam logic [7:0] IDX_LAST  = 8'h0C;

  typedef enum logic [1:0] {
    VIC_OP_WRITE = 2'b00,
    VIC_OP_CLR   = 2'b01,
    VIC_OP_SET   = 2'b10,
    VIC_OP_INV   = 2'b11
  } vic_op_t;

  // Control word fields
  localparam int MULTI_HANDLER_SELECT_BIT = 12;
  localparam int TPC_LSB  = 8;
  localparam int EP_LSB   = 0;
  localparam logic [31:0] CTRL_MASK  = 32'h0000_171F;
  // State word fields
  localparam int SRIPL_LSB = 8;
  localparam int VEC_LSB   = 0;
  localparam logic [31:0] STATE_MASK = 32'h0000_073F;
  localparam logic [31:0] FULL_MASK  = 32'hFFFF_FFFF;
  localparam logic [31:0] PRIO_MASK  = 32'h1F1F_1F1F;
  localparam logic [31:0] ZERO_WORD  = 32'h0000_0000;

  localparam logic [2:0]  TPC_OFF    = 3'h0;
  localparam logic [2:0]  PRI_OFF    = 3'h0;
  localparam logic [31:0] CNT_ONE    = 32'h0000_0001;
  localparam logic [1:0]  RESP_OKAY  = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;
endpackage : vic_pkg

// ==== design/vic_ext_edge.sv ====
/*
  Edge detectors for the external interrupt pins.
  Assumes pins are asynchronous; each passes two flip-flops before use.
*/
module vic_ext_edge (
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         rst_n,
  // Pins and polarity
  input  wire logic [vic_pkg::NUM_EXT-1:0]  extPin,
  input  wire logic [vic_pkg::NUM_EXT-1:0]  risingSel,
  // One-cycle edge events
  output logic      [vic_pkg::NUM_EXT-1:0]  edgeHit
);
  import vic_pkg::*;

  genvar g;
  generate
    for (g = 0; g < NUM_EXT; g++) begin : gEdge
      logic meta_r;
      logic sync_r;
      logic last_r;
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_r <= 1'b0;
          sync_r <= 1'b0;
          last_r <= 1'b0;
        end else begin
          meta_r <= extPin[g];
          sync_r <= meta_r;
          last_r <= sync_r;
        end
      end
      // Rising when polarity bit is one, falling when zero
      assign edgeHit[g] = risingSel[g] ? (sync_r & ~last_r) : (~sync_r & last_r);
    end
  endgenerate
endmodule : vic_ext_edge

// ==== design/vic_top.sv ====
/*
  Interrupt controller control and status: control word, state word, proximity
  reload, request flags, enables and priorities, arbitration and proximity hold.
  Assumes an AXI4-Lite master on the same clock, source pulses on the same clock,
  and external interrupt pins that are asynchronous.
*/
module vic_top (
  // Clock and reset
  input  wire logic                           clk,
  input  wire logic                           rst_n,
  // AXI4-Lite write address
  input  wire logic                           awvalid,
  output logic                                awready,
  input  wire logic [vic_pkg::ADDR_W-1:0]     awaddr,
  input  wire logic [2:0]                     awprot,
  // AXI4-Lite write data
  input  wire logic                           wvalid,
  output logic                                wready,
  input  wire logic [vic_pkg::DATA_W-1:0]     wdata,
  input  wire logic [3:0]                     wstrb,
  // AXI4-Lite write response
  output logic                                bvalid,
  input  wire logic                           bready,
  output logic      [1:0]                     bresp,
  // AXI4-Lite read address
  input  wire logic                           arvalid,
  output logic                                arready,
  input  wire logic [vic_pkg::ADDR_W-1:0]     araddr,
  input  wire logic [2:0]                     arprot,
  // AXI4-Lite read data
  output logic                                rvalid,
  input  wire logic                           rready,
  output logic      [vic_pkg::DATA_W-1:0]     rdata,
  output logic      [1:0]                     rresp,
  // Interrupt sources
  input  wire logic [vic_pkg::NUM_SRC-1:0]    srcPulse,
  input  wire logic [vic_pkg::NUM_EXT-1:0]    extPin,
  // Toward the processor core
  output logic                                irqReq,
  output logic      [2:0]                     irqLevel,
  output logic      [vic_pkg::IDX_W-1:0]      irqVector,
  output logic                                multiVector
);
  import vic_pkg::*;

  logic                 awready_r;
  logic                 wready_r;
  logic                 bvalid_r;
  logic [1:0]           bresp_r;
  logic                 arready_r;
  logic                 rvalid_r;
  logic [DATA_W-1:0]    rdata_r;
  logic [1:0]           rresp_r;
  logic                 awHeld_r;
  logic                 wHeld_r;
  logic [ADDR_W-1:0]    wAddr_r;
  logic [DATA_W-1:0]    wData_r;
  logic [3:0]           wStrb_r;
  logic [DATA_W-1:0]    ctrl_r;
  logic [2:0]           sripl_r;
  logic [IDX_W-1:0]     vec_r;
  logic [DATA_W-1:0]    prox_r;
  logic [DATA_W-1:0]    flag_r;
  logic [DATA_W-1:0]    flag_nxt;
  logic [DATA_W-1:0]    en_r;
  logic [DATA_W-1:0]    prio_r [NUM_PRIW];
  logic [DATA_W-1:0]    proxCnt_r;
  logic                 irqReq_r;
  logic [2:0]           irqLevel_r;
  logic [IDX_W-1:0]     irqVector_r;
  logic                 doWrite;
  logic [7:0]           wIdx;
  vic_op_t              wOp;
  logic [DATA_W-1:0]    wCur;
  logic [DATA_W-1:0]    wMask;
  logic [DATA_W-1:0]    wByteMask;
  logic [DATA_W-1:0]    wNew;
  logic                 wHit;
  logic [7:0]           rIdx;
  logic [DATA_W-1:0]    rWord;
  logic [DATA_W-1:0]    hwSet;
  logic [NUM_EXT-1:0]   extHit;
  logic [2:0]           tpc;
  logic                 proxRun;
  logic                 proxTrig;
  logic                 found;
  logic [2:0]           bestPri;
  logic [1:0]           bestSub;
  logic [IDX_W-1:0]     bestIdx;

  assign awready     = awready_r;
  assign wready      = wready_r;
  assign bvalid      = bvalid_r;
  assign bresp       = bresp_r;
  assign arready     = arready_r;
  assign rvalid      = rvalid_r;
  assign rdata       = rdata_r;
  assign rresp       = rresp_r;
  assign irqReq      = irqReq_r;
  assign irqLevel    = irqLevel_r;
  assign irqVector   = irqVector_r;
  assign multiVector = ctrl_r[MULTI_HANDLER_SELECT_BIT];

  assign tpc     = ctrl_r[TPC_LSB +: 3];
  assign proxRun = (proxCnt_r != ZERO_WORD);

  vic_ext_edge uEdge (
    .clk       (clk),
    .rst_n     (rst_n),
    .extPin    (extPin),
    .risingSel (ctrl_r[EP_LSB +: NUM_EXT]),
    .edgeHit   (extHit)
  );

  assign hwSet = srcPulse | {{(NUM_SRC-NUM_EXT){1'b0}}, extHit};

  // Write channel capture, either order
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      awready_r <= 1'b0;
      awHeld_r  <= 1'b0;
      wAddr_r   <= '0;
    end else if (awvalid && awready_r) begin
      awready_r <= 1'b0;
      awHeld_r  <= 1'b1;
      wAddr_r   <= awaddr;
    end else begin
      if (doWrite) begin
        awHeld_r <= 1'b0;
      end
      if (!awHeld_r && !bvalid_r) begin
        awready_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wready_r <= 1'b0;
      wHeld_r  <= 1'b0;
      wData_r  <= '0;
      wStrb_r  <= '0;
    end else if (wvalid && wready_r) begin
      wready_r <= 1'b0;
      wHeld_r  <= 1'b1;
      wData_r  <= wdata;
      wStrb_r  <= wstrb;
    end else begin
      if (doWrite) begin
        wHeld_r <= 1'b0;
      end
      if (!wHeld_r && !bvalid_r) begin
        wready_r <= 1'b1;
      end
    end
  end

  assign doWrite = awHeld_r && wHeld_r && !bvalid_r;
  assign wIdx    = wAddr_r[IDX_LSB +: 8];
  assign wOp     = vic_op_t'(wAddr_r[OP_LSB +: 2]);
  assign wHit    = (wIdx <= IDX_LAST);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bvalid_r <= 1'b0;
      bresp_r  <= RESP_OKAY;
    end else if (doWrite) begin
      bvalid_r <= 1'b1;
      bresp_r  <= wHit ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // Alias arithmetic on the addressed word
  always_comb begin
    case (wIdx)
      IDX_CTRL:  wCur = ctrl_r;
      IDX_STATE: wCur = {21'h0, sripl_r, 2'b00, vec_r};
      IDX_PROX:  wCur = prox_r;
      IDX_FLAG:  wCur = flag_r;
      IDX_EN:    wCur = en_r;
      default:   wCur = wHit ? prio_r[3'(wIdx - IDX_PRIO0)] : ZERO_WORD;
    endcase
    case (wIdx)
      IDX_CTRL:                   wMask = CTRL_MASK;
      IDX_STATE:                  wMask = STATE_MASK;
      IDX_PROX, IDX_FLAG, IDX_EN: wMask = FULL_MASK;
      default:                    wMask = wHit ? PRIO_MASK : ZERO_WORD;
    endcase
    for (int b = 0; b < 4; b++) begin
      wByteMask[b*8 +: 8] = {8{wStrb_r[b]}};
    end
    unique case (wOp)
      VIC_OP_WRITE: wNew = wData_r;
      VIC_OP_CLR:   wNew = wCur & ~wData_r;
      VIC_OP_SET:   wNew = wCur | wData_r;
      VIC_OP_INV:   wNew = wCur ^ wData_r;
    endcase
    wNew = ((wNew & wByteMask) | (wCur & ~wByteMask)) & wMask;
  end

  // Control, reload, enable and priority words
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= ZERO_WORD;
      prox_r <= ZERO_WORD;
      en_r   <= ZERO_WORD;
      for (int i = 0; i < NUM_PRIW; i++) begin
        prio_r[i] <= ZERO_WORD;
      end
    end else if (doWrite && wHit) begin
      case (wIdx)
        IDX_CTRL:            ctrl_r <= wNew;
        IDX_PROX:            prox_r <= wNew;
        IDX_EN:              en_r <= wNew;
        IDX_STATE, IDX_FLAG: ;
        default:             prio_r[3'(wIdx - IDX_PRIO0)] <= wNew;
      endcase
    end
  end

  // Request flags: a source event wins over a software clear
  always_comb begin
    flag_nxt = flag_r;
    if (doWrite && wIdx == IDX_FLAG) begin
      flag_nxt = wNew;
    end
    flag_nxt = flag_nxt | hwSet;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_r <= ZERO_WORD;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  // Arbitration over enabled, prioritised, unheld requests
  always_comb begin
    logic [2:0] pri;
    logic [1:0] sub;
    logic       elig;
    pri      = PRI_OFF;
    sub      = 2'b00;
    elig     = 1'b0;
    found    = 1'b0;
    bestPri  = PRI_OFF;
    bestSub  = 2'b00;
    bestIdx  = '0;
    proxTrig = 1'b0;
    for (int i = 0; i < NUM_SRC; i++) begin
      pri  = prio_r[i/4][(i%4)*SLOT_W + PRI_LSB +: 3];
      sub  = prio_r[i/4][(i%4)*SLOT_W + SUB_LSB +: 2];
      elig = flag_r[i] && en_r[i] && (pri != PRI_OFF);
      if (proxRun && tpc != TPC_OFF && pri <= tpc) begin
        elig = 1'b0;
      end
      if (elig && (!found || {pri, sub} > {bestPri, bestSub})) begin
        found   = 1'b1;
        bestPri = pri;
        bestSub = sub;
        bestIdx = IDX_W'(i);
      end
      if (hwSet[i] && !flag_r[i] && en_r[i] && pri != PRI_OFF && tpc != TPC_OFF && pri <= tpc) begin
        proxTrig = 1'b1;
      end
    end
  end

  // Proximity timer countdown
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      proxCnt_r <= ZERO_WORD;
    end else if (tpc == TPC_OFF) begin
      proxCnt_r <= ZERO_WORD;
    end else if (proxRun) begin
      proxCnt_r <= proxCnt_r - CNT_ONE;
    end else if (proxTrig) begin
      proxCnt_r <= prox_r;
    end
  end

  // Presentation to the core
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irqReq_r    <= 1'b0;
      irqLevel_r  <= PRI_OFF;
      irqVector_r <= '0;
    end else begin
      irqReq_r    <= found;
      irqLevel_r  <= found ? bestPri : PRI_OFF;
      irqVector_r <= ctrl_r[MULTI_HANDLER_SELECT_BIT] ? bestIdx : '0;
    end
  end

  // State word: hardware update wins over a software write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sripl_r <= PRI_OFF;
      vec_r   <= '0;
    end else if (found) begin
      sripl_r <= bestPri;
      vec_r   <= bestIdx;
    end else if (doWrite && wIdx == IDX_STATE) begin
      sripl_r <= wNew[SRIPL_LSB +: 3];
      vec_r   <= wNew[VEC_LSB +: IDX_W];
    end
  end

  // Read channel
  assign rIdx = araddr[IDX_LSB +: 8];

  always_comb begin
    case (rIdx)
      IDX_CTRL:  rWord = ctrl_r & CTRL_MASK;
      IDX_STATE: rWord = {21'h0, sripl_r, 2'b00, vec_r};
      IDX_PROX:  rWord = prox_r;
      IDX_FLAG:  rWord = flag_r;
      IDX_EN:    rWord = en_r;
      default:   rWord = (rIdx <= IDX_LAST) ? prio_r[3'(rIdx - IDX_PRIO0)] : ZERO_WORD;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= ZERO_WORD;
      rresp_r   <= RESP_OKAY;
    end else if (arvalid && arready_r) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b1;
      rdata_r   <= rWord;
      rresp_r   <= (rIdx <= IDX_LAST) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_r) begin
      if (rready) begin
        rvalid_r <= 1'b0;
      end
    end else begin
      arready_r <= 1'b1;
    end
  end
endmodule : vic_top

// ==== test/vic_top_monitor.sv ====
/*
  Checker for the interrupt controller ports.
  Assumes it is bound to vic_top and sees its ports only.
*/
module vic_top_monitor (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // Register bus
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [11:0] araddr,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp,
  // Core side
  input wire logic        irqReq,
  input wire logic [2:0]  irqLevel,
  input wire logic [5:0]  irqVector,
  input wire logic        multiVector
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_write_answer: assert property (
    awvalid && awready && wvalid && wready |-> ##2 bvalid) else $error("write not answered");
  a_read_answer: assert property (
    arvalid && arready |=> rvalid) else $error("read not answered");
  a_bresp_stands: assert property (
    $fell(bvalid) |-> $past(bready)) else $error("write response dropped early");
  a_rdata_stands: assert property (
    $fell(rvalid) |-> $past(rready)) else $error("read data dropped early");
  a_unmapped_read: assert property (
    arvalid && arready && araddr[11:4] > 8'h0C |=> rresp == 2'b10 && rdata == 32'h0000_0000)
    else $error("unmapped read not refused");
  a_idle_level: assert property (
    !irqReq |-> irqLevel == 3'h0) else $error("level without request");
  a_level_valid: assert property (
    irqReq |-> irqLevel != 3'h0) else $error("request at level zero");
  a_single_vector: assert property (
    !multiVector && !$past(multiVector) |-> irqVector == 6'h00) else $error("vector in single mode");
endmodule : vic_top_monitor

bind vic_top vic_top_monitor u_mon (.clk, .rst_n, .awvalid, .awready, .wvalid, .wready, .bvalid,
  .bready, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp, .irqReq, .irqLevel,
  .irqVector, .multiVector);

// ==== test/vic_core_model.sv ====
/*
  Processor core model: keeps the last presented level and vector.
  Assumes the controller outputs are registered on the same clock.
*/
module vic_core_model (
  // Clock and reset
  input wire logic  clk,
  input wire logic  rst_n,
  // From controller
  input wire logic        irqReq,
  input wire logic [2:0]  irqLevel,
  input wire logic [5:0]  irqVector,
  // Seen by the core
  output logic [2:0] lastLevel_r,
  output logic [5:0] lastVector_r
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lastLevel_r  <= 3'h0;
      lastVector_r <= 6'h00;
    end else if (irqReq) begin
      lastLevel_r  <= irqLevel;
      lastVector_r <= irqVector;
    end
  end
endmodule : vic_core_model

// ==== test/tb_top.sv ====
/*
  Testbench for vic_top: register bus tasks and source stimulus.
  Assumes the checker is bound to the design and the core model sits beside it.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import vic_pkg::*;
  `define CHK(g, e) begin totalChecks++; if ((g) !== (e)) begin failCount++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end

  logic        clk = 1'b0, rst_n = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000, srcPulse = 32'h0000_0000, rd, rdata;
  logic [4:0]  extPin = 5'h00;
  logic [1:0]  rr, br, bresp, rresp;
  logic        awready, wready, bvalid, arready, rvalid, irqReq, multiVector;
  logic [2:0]  irqLevel, lastLevel_r;
  logic [5:0]  irqVector, lastVector_r;
  int          failCount = 0, totalChecks = 0;

  always #25 clk = ~clk;

  vic_top DUT (.clk(clk), .rst_n(rst_n), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hF), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .srcPulse(srcPulse), .extPin(extPin), .irqReq(irqReq), .irqLevel(irqLevel),
    .irqVector(irqVector), .multiVector(multiVector));
  vic_core_model u_core (.clk(clk), .rst_n(rst_n), .irqReq(irqReq), .irqLevel(irqLevel),
    .irqVector(irqVector), .lastLevel_r(lastLevel_r), .lastVector_r(lastVector_r));

  task automatic axw(input logic [11:0] a, input logic [31:0] d);
    logic ad = 1'b0, dd = 1'b0;
    @(posedge clk);
    awvalid <= 1'b1;
    awaddr  <= a;
    wvalid  <= 1'b1;
    wdata   <= d;
    bready  <= 1'b1;
    while (!(ad && dd)) begin
      @(posedge clk);
      if (awvalid && awready) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        dd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (!bvalid);
    br = bresp;
    bready <= 1'b0;
  endtask : axw

  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    @(posedge clk);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk); while (!rvalid);
    rd = rdata;
    rr = rresp;
    rready <= 1'b0;
    `CHK(rd, e)
  endtask : rc

  task automatic pulse(input int s);
    @(posedge clk);
    srcPulse <= 32'h0000_0001 << s;
    @(posedge clk);
    srcPulse <= 32'h0000_0000;
  endtask : pulse

  task report_and_stop;
    $display("checks %0d, mismatches %0d", totalChecks, failCount);
    if (failCount == 0 && totalChecks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (4000) @(posedge clk);
    failCount++;
    report_and_stop();
  end

  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    for (int i = 0; i < 4; i++) rc(12'(i * 16), 32'h0000_0000);
    axw(12'h000, 32'hFFFF_FFFF);
    rc(12'h000, 32'h0000_171F);
    `CHK(multiVector, 1'b1)
    axw(12'h004, 32'h0000_1000);
    rc(12'h000, 32'h0000_071F);
    `CHK(multiVector, 1'b0)
    axw(12'h00C, 32'h0000_0003);
    rc(12'h000, 32'h0000_071C);
    axw(12'h008, 32'h0000_0001);
    rc(12'h000, 32'h0000_071D);
    axw(12'h000, 32'h0000_0001);
    axw(12'h020, 32'hA5A5_5A5A);
    rc(12'h020, 32'hA5A5_5A5A);
    axw(12'h030, 32'hFFFF_FFFF);
    rc(12'h030, 32'hFFFF_FFFF);
    axw(12'h034, 32'hFFFF_FFFF);
    rc(12'h030, 32'h0000_0000);
    rc(12'h0D0, 32'h0000_0000);
    `CHK(rr, 2'b10)
    axw(12'h0D0, 32'hFFFF_FFFF);
    `CHK(br, 2'b10)
    // Source 9 at priority 5, subpriority 2
    axw(12'h070, 32'h0000_1600);
    axw(12'h040, 32'h0000_0200);
    pulse(9);
    repeat (2) @(posedge clk);
    `CHK(irqReq, 1'b1)
    `CHK(irqLevel, 3'h5)
    rc(12'h010, 32'h0000_0509);
    `CHK(lastLevel_r, 3'h5)
    `CHK(lastVector_r, 6'h00)
    axw(12'h044, 32'h0000_0200);
    repeat (3) @(posedge clk);
    `CHK(irqReq, 1'b0)
    axw(12'h048, 32'h0000_0200);
    axw(12'h074, 32'h0000_1C00);
    repeat (3) @(posedge clk);
    `CHK(irqReq, 1'b0)
    // Pin 0 rising, pin 1 falling
    axw(12'h034, 32'hFFFF_FFFF);
    extPin <= 5'h03;
    repeat (6) @(posedge clk);
    rc(12'h030, 32'h0000_0001);
    extPin <= 5'h00;
    repeat (6) @(posedge clk);
    rc(12'h030, 32'h0000_0003);
    // Threshold 4, reload 32, source 2 at priority 3
    axw(12'h034, 32'hFFFF_FFFF);
    axw(12'h000, 32'h0000_0400);
    axw(12'h020, 32'h0000_0020);
    axw(12'h050, 32'h000C_0000);
    axw(12'h048, 32'h0000_0004);
    pulse(2);
    repeat (3) @(posedge clk);
    `CHK(irqReq, 1'b0)
    repeat (26) @(posedge clk);
    `CHK(irqReq, 1'b0)
    repeat (6) @(posedge clk);
    `CHK(irqReq, 1'b1)
    `CHK(irqLevel, 3'h3)
    axw(12'h034, 32'h0000_0004);
    axw(12'h004, 32'h0000_0700);
    pulse(2);
    repeat (2) @(posedge clk);
    `CHK(irqReq, 1'b1)
    // Multi-vector: source 3 at priority 3, subpriority 1 beats source 2
    axw(12'h008, 32'h0000_1000);
    repeat (2) @(posedge clk);
    `CHK(irqVector, 6'h02)
    `CHK(lastVector_r, 6'h02)
    axw(12'h058, 32'h0D00_0000);
    axw(12'h048, 32'h0000_0008);
    pulse(3);
    repeat (2) @(posedge clk);
    `CHK(irqVector, 6'h03)
    report_and_stop();
  end
endmodule : tb_top
